/* hw/bb_test_pkg.sv */
// package: register map, field positions and carrier structs
package bb_test_pkg;
  localparam logic [7:0] OFS_TEST_MODES_FIRST  = 8'h40;
  localparam logic [7:0] OFS_TEST_MODES_SECOND = 8'h42;
  localparam logic [7:0] OFS_TEST_BUS_SELECT   = 8'h44;
  localparam logic [7:0] OFS_ED_THRESHOLD      = 8'h46;
  localparam logic [7:0] OFS_DELAY_SPREAD_THR  = 8'h48;
  localparam logic [7:0] OFS_TONE_RSSI_FORCE   = 8'h4a;
  localparam logic [7:0] OFS_SNR_THR_FIRST     = 8'h4c;
  localparam logic [7:0] OFS_SNR_THR_SECOND    = 8'h4e;
  localparam logic [7:0] REG_RESET             = 8'h00;
  // first test register fields
  localparam int B1_DAC_SRC   = 7;
  localparam int B1_HIGH_RATE = 6;
  localparam int B1_LEN_CNT   = 5;
  localparam int B1_TB_INPUT  = 4;
  localparam int B1_NO_SPREAD = 3;
  localparam int B1_NO_SCRAM  = 2;
  localparam int B1_PRS_44    = 1;
  localparam int B1_PRS_22    = 0;
  // second test register fields
  localparam int B2_NO_COH_AGC = 7;
  localparam int B2_FORCE_LOCK = 6;
  localparam int B2_NO_DC_COMP = 5;
  localparam int B2_CONV_BYP   = 4;
  localparam int B2_NO_TADJ    = 3;
  localparam int B2_LOOPBACK   = 2;
  localparam int B2_PRS_LOW    = 1;
  localparam int B2_PRS_HIGH   = 0;
  // other fields
  localparam int ED_ABS_BIT    = 7;
  localparam int FORCE_DEF_BIT = 6;
  localparam int FORCE_CAL_BIT = 5;
  localparam int DAC_TEST_MODE7 = 7;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;

  // datapath measurements supplied from the receiver
  typedef struct packed {
    logic [7:0] rssi;
    logic [7:0] noise_floor;
    logic       continuous_tone;
    logic [4:0] delay_spread;
    logic       service_bit2;
    logic       cfg_six_bit2;
  } meas_s;

  // decoded controls driven into the datapath
  typedef struct packed {
    logic       dac_low_rate_iq;
    logic       force_high_rate;
    logic       length_cnt_en;
    logic       test_bus_oe;
    logic       spread_off;
    logic       scram_taps_zero;
    logic       prs44_en;
    logic       prs22_en;
    logic       prs44_init;
    logic       prs22_init;
    logic       coh_agc_off;
    logic       locked_tracking;
    logic       bit_tracking_off;
    logic       dc_comp_off;
    logic       conv_bypass;
    logic       loopback;
    logic       acq_lock_in;
    logic [5:0] i_sample;
    logic [5:0] q_sample;
    logic [7:0] test_bus_addr;
    logic       energy_detect;
    logic       use_default_cmf;
  } ctrl_s;
endpackage

/* hw/bb_test_regs.sv */
// register bank for baseband test modes and matched-filter weight choice
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
module bb_test_regs
  import bb_test_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire bus_req_s   bus,
  output logic [7:0]      rdata,
  input  wire meas_s      meas,
  input  wire logic [2:0] dac_test_mode,
  input  wire logic       prs_bit,
  input  wire logic       serial_data_in_pin,
  input  wire logic [7:0] test_bus_input,
  output ctrl_s           ctrl
);

  typedef struct packed {
    logic [7:0] mode1;
    logic [7:0] mode2;
    logic [7:0] tb_sel;
    logic [7:0] ed_thr;
    logic [7:0] ds_thr;
    logic [7:0] tone_thr;
    logic [7:0] snr1;
    logic [7:0] snr2;
    logic [7:0] rdata;
    logic [1:0] prs_zero_seen;
    logic [1:0] sdi_sync;
    logic [7:0] tb_in_meta;
    logic [7:0] tb_in_sync;
    ctrl_s      ctrl;
  } state_s;

  state_s st_q;
  state_s st_d;

  // relative threshold adds the noise floor, saturating at 8 bits
  function automatic logic [7:0] add_sat(input logic [7:0] a,
                                         input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[8] ? 8'hff : s[7:0];
  endfunction

  logic [7:0] ed_level;
  logic       cmf_auto_default;

  // measurement compares for energy detect and matched filter choice
  always_comb begin
    ed_level = st_q.ed_thr[ED_ABS_BIT] ? {1'b0, st_q.ed_thr[6:0]}
             : add_sat({1'b0, st_q.ed_thr[6:0]}, meas.noise_floor);
    cmf_auto_default =
      (meas.continuous_tone && meas.rssi <
        add_sat({3'h0, st_q.tone_thr[4:0]}, meas.noise_floor)) ||
      (!meas.continuous_tone && meas.rssi <
        add_sat({4'h0, st_q.snr1[3:0]}, meas.noise_floor)) ||
      (!meas.continuous_tone &&
        meas.delay_spread < st_q.ds_thr[4:0] && meas.rssi <
        add_sat({3'h0, st_q.snr2[4:0]}, meas.noise_floor));
  end

  // next state: register writes, read mux and decoded controls
  always_comb begin
    st_d = st_q;
    // pin-side inputs pass two flops before use
    st_d.sdi_sync   = {st_q.sdi_sync[0], serial_data_in_pin};
    st_d.tb_in_meta = test_bus_input;
    st_d.tb_in_sync = st_q.tb_in_meta;
    // full 8 bits stored, unused bits included
    if (bus.wr) begin
      unique case (bus.addr)
        OFS_TEST_MODES_FIRST:  st_d.mode1    = bus.wdata;
        OFS_TEST_MODES_SECOND: st_d.mode2    = bus.wdata;
        OFS_TEST_BUS_SELECT:   st_d.tb_sel   = bus.wdata;
        OFS_ED_THRESHOLD:      st_d.ed_thr   = bus.wdata;
        OFS_DELAY_SPREAD_THR:  st_d.ds_thr   = bus.wdata;
        OFS_TONE_RSSI_FORCE:   st_d.tone_thr = bus.wdata;
        OFS_SNR_THR_FIRST:     st_d.snr1     = bus.wdata;
        OFS_SNR_THR_SECOND:    st_d.snr2     = bus.wdata;
        default: ;
      endcase
    end
    // unmapped reads return zero; data stands one cycle only
    st_d.rdata = REG_RESET;
    if (bus.rd) begin
      unique case (bus.addr)
        OFS_TEST_MODES_FIRST:  st_d.rdata = st_q.mode1;
        OFS_TEST_MODES_SECOND: st_d.rdata = st_q.mode2;
        OFS_TEST_BUS_SELECT:   st_d.rdata = st_q.tb_sel;
        OFS_ED_THRESHOLD:      st_d.rdata = st_q.ed_thr;
        OFS_DELAY_SPREAD_THR:  st_d.rdata = st_q.ds_thr;
        OFS_TONE_RSSI_FORCE:   st_d.rdata = st_q.tone_thr;
        OFS_SNR_THR_FIRST:     st_d.rdata = st_q.snr1;
        OFS_SNR_THR_SECOND:    st_d.rdata = st_q.snr2;
        default:               st_d.rdata = REG_RESET;
      endcase
    end
    // a generator may only run after its enable has been seen low;
    // a 1 written without a prior 0 is held off so logic is initialised
    if (!st_q.mode1[B1_PRS_44]) st_d.prs_zero_seen[1] = 1'b1;
    if (!st_q.mode1[B1_PRS_22]) st_d.prs_zero_seen[0] = 1'b1;
    st_d.ctrl.prs44_en   = st_q.mode1[B1_PRS_44] & st_q.prs_zero_seen[1];
    st_d.ctrl.prs22_en   = st_q.mode1[B1_PRS_22] & st_q.prs_zero_seen[0];
    st_d.ctrl.prs44_init = ~st_q.mode1[B1_PRS_44];
    st_d.ctrl.prs22_init = ~st_q.mode1[B1_PRS_22];
    st_d.ctrl.dac_low_rate_iq = (dac_test_mode == 3'(DAC_TEST_MODE7)) &
                                st_q.mode1[B1_DAC_SRC];
    st_d.ctrl.force_high_rate = st_q.mode1[B1_HIGH_RATE];
    st_d.ctrl.length_cnt_en   = st_q.mode1[B1_LEN_CNT];
    st_d.ctrl.test_bus_oe     = ~st_q.mode1[B1_TB_INPUT];
    st_d.ctrl.spread_off      = st_q.mode1[B1_NO_SPREAD];
    st_d.ctrl.scram_taps_zero = st_q.mode1[B1_NO_SCRAM];
    st_d.ctrl.coh_agc_off     = st_q.mode2[B2_NO_COH_AGC];
    // stopping time adjust wins over forced or detected locking
    st_d.ctrl.bit_tracking_off = st_q.mode2[B2_NO_TADJ];
    st_d.ctrl.locked_tracking  = ~st_q.mode2[B2_NO_TADJ] &
      (st_q.mode2[B2_FORCE_LOCK] |
       (meas.service_bit2 & meas.cfg_six_bit2));
    st_d.ctrl.dc_comp_off = st_q.mode2[B2_NO_DC_COMP];
    st_d.ctrl.loopback    = st_q.mode2[B2_LOOPBACK];
    st_d.ctrl.acq_lock_in = st_q.mode2[B2_LOOPBACK] & st_q.sdi_sync[1];
    st_d.ctrl.conv_bypass = st_q.mode2[B2_CONV_BYP] |
                            st_q.mode2[B2_LOOPBACK];
    // bypass samples: top four bits from test bus, low bits zero
    if (st_q.mode2[B2_CONV_BYP]) begin
      st_d.ctrl.i_sample = {st_q.tb_in_sync[3:0], 2'b00};
      st_d.ctrl.q_sample = {st_q.tb_in_sync[7:4], 2'b00};
    end else begin
      st_d.ctrl.i_sample = 6'h00;
      st_d.ctrl.q_sample = 6'h00;
    end
    st_d.ctrl.test_bus_addr = st_q.tb_sel;
    if (st_q.mode2[B2_PRS_LOW])
      st_d.ctrl.test_bus_addr[2:0] = {3{prs_bit}};
    if (st_q.mode2[B2_PRS_HIGH])
      st_d.ctrl.test_bus_addr[7:3] = {5{prs_bit}};
    st_d.ctrl.energy_detect = meas.rssi > ed_level;
    // both force bits set is undefined; default wins here
    if (st_q.tone_thr[FORCE_DEF_BIT])
      st_d.ctrl.use_default_cmf = 1'b1;
    else if (st_q.tone_thr[FORCE_CAL_BIT])
      st_d.ctrl.use_default_cmf = 1'b0;
    else
      st_d.ctrl.use_default_cmf = cmf_auto_default;
  end

  // single state register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;
  assign ctrl  = st_q.ctrl;

  property p_rd_back;
    @(posedge mclk) disable iff (!nrst)
      (bus.wr && bus.addr == OFS_SNR_THR_FIRST) ##1
      (bus.rd && bus.addr == OFS_SNR_THR_FIRST && !bus.wr)
      |=> rdata == $past(bus.wdata, 2);
  endproperty
  a_rd_back: assert property (p_rd_back)
    else $error("register read back mismatch");

  property p_high_rate;
    @(posedge mclk) disable iff (!nrst)
      (bus.wr && bus.addr == OFS_TEST_MODES_FIRST) |=> ##1
      ctrl.force_high_rate == $past(bus.wdata[B1_HIGH_RATE], 2);
  endproperty
  a_high_rate: assert property (p_high_rate)
    else $error("force high rate wrong");

  property p_tb_oe;
    @(posedge mclk) disable iff (!nrst)
      (bus.wr && bus.addr == OFS_TEST_MODES_FIRST &&
       bus.wdata[B1_TB_INPUT]) |=> ##1 !ctrl.test_bus_oe;
  endproperty
  a_tb_oe: assert property (p_tb_oe)
    else $error("test bus not tristated");

  property p_tadj_over;
    @(posedge mclk) disable iff (!nrst)
      st_q.mode2[B2_NO_TADJ] |=> !ctrl.locked_tracking &&
                                 ctrl.bit_tracking_off;
  endproperty
  a_tadj_over: assert property (p_tadj_over)
    else $error("tracking not disabled");

  property p_force_def;
    @(posedge mclk) disable iff (!nrst)
      st_q.tone_thr[FORCE_DEF_BIT] |=> ctrl.use_default_cmf;
  endproperty
  a_force_def: assert property (p_force_def)
    else $error("default weights not forced");

  property p_prs_init;
    @(posedge mclk) disable iff (!nrst)
      ctrl.prs44_en |-> st_q.prs_zero_seen[1];
  endproperty
  a_prs_init: assert property (p_prs_init)
    else $error("generator enabled without init");

  property p_bypass;
    @(posedge mclk) disable iff (!nrst)
      $past(st_q.mode2[B2_CONV_BYP]) |->
      ctrl.i_sample[1:0] == 2'b00 &&
      ctrl.i_sample[5:2] == $past(st_q.tb_in_sync[3:0]);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass sample wrong");

  property p_ed_abs;
    @(posedge mclk) disable iff (!nrst)
      (st_q.ed_thr[ED_ABS_BIT] && meas.rssi > {1'b0, st_q.ed_thr[6:0]})
      |=> ctrl.energy_detect;
  endproperty
  a_ed_abs: assert property (p_ed_abs)
    else $error("energy detect missed");

  // remaining decodes, each checked one edge after the register
  property p_dac_src;
    @(posedge mclk) disable iff (!nrst)
      (dac_test_mode == 3'(DAC_TEST_MODE7) && st_q.mode1[B1_DAC_SRC])
      |=> ctrl.dac_low_rate_iq;
  endproperty
  a_dac_src: assert property (p_dac_src)
    else $error("dac source not low rate samples");

  property p_dac_off;
    @(posedge mclk) disable iff (!nrst)
      dac_test_mode != 3'(DAC_TEST_MODE7) |=> !ctrl.dac_low_rate_iq;
  endproperty
  a_dac_off: assert property (p_dac_off)
    else $error("dac source set outside test mode");

  property p_len_cnt;
    @(posedge mclk) disable iff (!nrst)
      ctrl.length_cnt_en == $past(st_q.mode1[B1_LEN_CNT]);
  endproperty
  a_len_cnt: assert property (p_len_cnt)
    else $error("length counter enable wrong");

  property p_spread;
    @(posedge mclk) disable iff (!nrst)
      ctrl.spread_off == $past(st_q.mode1[B1_NO_SPREAD]);
  endproperty
  a_spread: assert property (p_spread)
    else $error("spreading control wrong");

  property p_scram;
    @(posedge mclk) disable iff (!nrst)
      ctrl.scram_taps_zero == $past(st_q.mode1[B1_NO_SCRAM]);
  endproperty
  a_scram: assert property (p_scram)
    else $error("scrambler tap control wrong");

  property p_coh_agc;
    @(posedge mclk) disable iff (!nrst)
      ctrl.coh_agc_off == $past(st_q.mode2[B2_NO_COH_AGC]);
  endproperty
  a_coh_agc: assert property (p_coh_agc)
    else $error("coherent agc control wrong");

  property p_lock_force;
    @(posedge mclk) disable iff (!nrst)
      (!st_q.mode2[B2_NO_TADJ] && st_q.mode2[B2_FORCE_LOCK])
      |=> ctrl.locked_tracking;
  endproperty
  a_lock_force: assert property (p_lock_force)
    else $error("locked tracking not forced");

  property p_lock_auto;
    @(posedge mclk) disable iff (!nrst)
      (!st_q.mode2[B2_NO_TADJ] && !st_q.mode2[B2_FORCE_LOCK]) |=>
      ctrl.locked_tracking ==
        ($past(meas.service_bit2) && $past(meas.cfg_six_bit2));
  endproperty
  a_lock_auto: assert property (p_lock_auto)
    else $error("automatic locked tracking wrong");

  property p_dc_comp;
    @(posedge mclk) disable iff (!nrst)
      ctrl.dc_comp_off == $past(st_q.mode2[B2_NO_DC_COMP]);
  endproperty
  a_dc_comp: assert property (p_dc_comp)
    else $error("dc offset compensation control wrong");

  property p_loopback;
    @(posedge mclk) disable iff (!nrst)
      st_q.mode2[B2_LOOPBACK] |=> ctrl.loopback && ctrl.conv_bypass &&
      ctrl.acq_lock_in == $past(st_q.sdi_sync[1]);
  endproperty
  a_loopback: assert property (p_loopback)
    else $error("loopback controls wrong");

  property p_acq_idle;
    @(posedge mclk) disable iff (!nrst)
      !st_q.mode2[B2_LOOPBACK] |=> !ctrl.acq_lock_in && !ctrl.loopback;
  endproperty
  a_acq_idle: assert property (p_acq_idle)
    else $error("lock input active outside loopback");

  property p_prs_low;
    @(posedge mclk) disable iff (!nrst)
      st_q.mode2[B2_PRS_LOW] |=>
      ctrl.test_bus_addr[2:0] == {3{$past(prs_bit)}};
  endproperty
  a_prs_low: assert property (p_prs_low)
    else $error("sequence not on lower address bits");

  property p_prs_high;
    @(posedge mclk) disable iff (!nrst)
      st_q.mode2[B2_PRS_HIGH] |=>
      ctrl.test_bus_addr[7:3] == {5{$past(prs_bit)}};
  endproperty
  a_prs_high: assert property (p_prs_high)
    else $error("sequence not on upper address bits");

  property p_tb_addr;
    @(posedge mclk) disable iff (!nrst)
      (!st_q.mode2[B2_PRS_LOW] && !st_q.mode2[B2_PRS_HIGH])
      |=> ctrl.test_bus_addr == $past(st_q.tb_sel);
  endproperty
  a_tb_addr: assert property (p_tb_addr)
    else $error("test bus address wrong");

  property p_ed_rel;
    @(posedge mclk) disable iff (!nrst)
      (!st_q.ed_thr[ED_ABS_BIT] && meas.rssi <= {1'b0, st_q.ed_thr[6:0]})
      |=> !ctrl.energy_detect;
  endproperty
  a_ed_rel: assert property (p_ed_rel)
    else $error("energy detect below relative level");

  property p_force_cal;
    @(posedge mclk) disable iff (!nrst)
      (!st_q.tone_thr[FORCE_DEF_BIT] && st_q.tone_thr[FORCE_CAL_BIT])
      |=> !ctrl.use_default_cmf;
  endproperty
  a_force_cal: assert property (p_force_cal)
    else $error("calculated weights not forced");

  property p_cmf_tone;
    @(posedge mclk) disable iff (!nrst)
      (!st_q.tone_thr[FORCE_DEF_BIT] && !st_q.tone_thr[FORCE_CAL_BIT] &&
       meas.continuous_tone && meas.rssi < {3'h0, st_q.tone_thr[4:0]})
      |=> ctrl.use_default_cmf;
  endproperty
  a_cmf_tone: assert property (p_cmf_tone)
    else $error("default weights missed under tone");

  property p_rd_idle;
    @(posedge mclk) disable iff (!nrst)
      !bus.rd |=> rdata == REG_RESET;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data left standing");

endmodule // bb_test_regs

/* sim/tb.sv */
// self-checking bench for the test-mode and filter-weight register bank
`timescale 1ns/100ps
module tb
  import bb_test_pkg::*;
;
  localparam logic [7:0][7:0] OFS = {OFS_SNR_THR_SECOND, OFS_SNR_THR_FIRST,
    OFS_TONE_RSSI_FORCE, OFS_DELAY_SPREAD_THR, OFS_ED_THRESHOLD,
    OFS_TEST_BUS_SELECT, OFS_TEST_MODES_SECOND, OFS_TEST_MODES_FIRST};
  localparam logic [3:0][7:0] BAD = {8'h41, 8'h50, 8'h3e, 8'h00};

  logic            mclk = 1'b0;
  logic            nrst = 1'b0;
  bus_req_s        bus;
  logic [7:0]      rdata;
  meas_s           meas;
  meas_s           mv;
  logic            prs_bit;
  logic            ser_in;
  logic [7:0]      tbi;
  logic [2:0]      dmode;
  ctrl_s           ctrl;
  ctrl_s           e;
  ctrl_s           g;
  logic [7:0][7:0] r;
  logic [31:0]     v;
  logic [31:0]     v2;
  logic [7:0]      lv;
  logic [31:0]     seed = 32'h06b5_7e5c;
  int              error_cnt = 0;
  int              tests_run = 0;

  // dac test mode is driven, so the source bit is also seen masked
  bb_test_regs dut (.mclk(mclk), .nrst(nrst), .bus(bus), .rdata(rdata),
    .meas(meas), .dac_test_mode(dmode), .prs_bit(prs_bit),
    .serial_data_in_pin(ser_in), .test_bus_input(tbi), .ctrl(ctrl));

  always #20 mclk = ~mclk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // saturating add, the level can never wrap below the noise floor
  function automatic logic [7:0] sat(logic [7:0] a, logic [7:0] nf);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, nf};
    return s[8] ? 8'hff : s[7:0];
  endfunction

  function automatic logic [7:0] det_level(logic [7:0] t, logic [7:0] nf);
    return t[7] ? {1'b0, t[6:0]} : sat({1'b0, t[6:0]}, nf);
  endfunction

  // expected decoded controls from register image and inputs
  function automatic ctrl_s exp_ctrl(logic [7:0][7:0] q, meas_s m,
                                     logic p, logic [7:0] t, logic s,
                                     logic [2:0] dm);
    ctrl_s c;
    logic  d;
    c = '0;
    {c.dac_low_rate_iq, c.force_high_rate, c.length_cnt_en} = q[0][7:5];
    // the source bit only counts in dac test mode 7
    c.dac_low_rate_iq = q[0][7] & (dm == 3'(DAC_TEST_MODE7));
    c.test_bus_oe = ~q[0][4];
    {c.spread_off, c.scram_taps_zero, c.prs44_en, c.prs22_en} = q[0][3:0];
    // generators sit in initialisation while their enable is low
    {c.prs44_init, c.prs22_init} = ~q[0][1:0];
    c.coh_agc_off = q[1][7];
    c.locked_tracking = ~q[1][3] &
                        (q[1][6] | (m.service_bit2 & m.cfg_six_bit2));
    c.bit_tracking_off = q[1][3];
    c.dc_comp_off = q[1][5];
    c.loopback = q[1][2];
    c.conv_bypass = q[1][4] | q[1][2];
    c.acq_lock_in = q[1][2] & s;
    // test bus samples only with the converter bypass bit itself
    if (q[1][4]) begin
      c.i_sample = {t[3:0], 2'b00};
      c.q_sample = {t[7:4], 2'b00};
    end
    c.test_bus_addr = q[2];
    if (q[1][1]) c.test_bus_addr[2:0] = {3{p}};
    if (q[1][0]) c.test_bus_addr[7:3] = {5{p}};
    c.energy_detect = m.rssi > det_level(q[3], m.noise_floor);
    d = (m.continuous_tone && m.rssi < sat({3'b000, q[5][4:0]}, m.noise_floor))
      || (!m.continuous_tone && m.rssi < sat({4'h0, q[6][3:0]}, m.noise_floor))
      || (!m.continuous_tone && m.delay_spread < q[4][4:0]
          && m.rssi < sat({3'b000, q[7][4:0]}, m.noise_floor));
    c.use_default_cmf = q[5][6] | (~q[5][5] & d);
    return c;
  endfunction

  task automatic chk(input string n, input logic [63:0] x,
                     input logic [63:0] y);
    tests_run++;
    if (x !== y) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, x, y);
    end
  endtask

  // write strobes may follow each other with no gap; idle ends a burst
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
  endtask

  task automatic idle();
    @(posedge mclk);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '0;
    #1;
    chk("rdata", {56'h0, x}, {56'h0, rdata});
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog sized well above the 30-iteration run
  initial begin
    repeat (6000) @(posedge mclk);
    error_cnt++;
    $display("Error watchdog expected done seen hang");
    close_out();
  end

  initial begin
    bus = '0;
    meas = '0;
    prs_bit = 1'b0;
    ser_in = 1'b0;
    tbi = 8'h00;
    dmode = 3'h0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    for (int k = 0; k < 8; k++) rd(OFS[k], REG_RESET);
    rd(8'h50, 8'h00);
    $display("test reset_values done");
    for (int i = 0; i < 30; i++) begin
      for (int k = 0; k < 8; k++) begin
        v = rnd();
        r[k] = v[7:0];
      end
      if (r[5][6]) r[5][5] = 1'b0;
      v = rnd();
      v2 = rnd();
      mv = meas_s'(v[23:0]);
      lv = det_level(r[3], mv.noise_floor);
      // corner cases on the detect and weight boundaries
      if (i % 5 == 1) mv.rssi = lv;
      else if (i % 5 == 2 && lv != 8'hff) mv.rssi = lv + 8'h01;
      else if (i % 5 == 3) begin
        mv.continuous_tone = 1'b0;
        mv.rssi = sat({4'h0, r[6][3:0]}, mv.noise_floor);
      end else if (i % 5 == 4) begin
        // tone with a weak signal lands under the tone threshold
        mv.continuous_tone = 1'b1;
        mv.rssi = 8'h00;
      end
      @(posedge mclk);
      meas <= mv;
      prs_bit <= v[24];
      ser_in <= v[25];
      tbi <= v2[7:0];
      dmode <= (i % 2 == 0) ? 3'(DAC_TEST_MODE7) : v2[18:16];
      // generator enables go through 0 before the random value
      wr(OFS[0], r[0] & 8'hfc);
      for (int k = 0; k < 8; k++) wr(OFS[k], r[k]);
      wr(BAD[i % 4], v2[15:8]);
      idle();
      repeat (4) @(posedge mclk);
      #1;
      e = exp_ctrl(r, mv, v[24], v2[7:0], v[25], dmode);
      g = ctrl;
      chk("dac_rate_len", 64'(e[38:36]), 64'(g[38:36]));
      chk("tbus_spread", 64'(e[35:33]), 64'(g[35:33]));
      chk("prs_ctrl", 64'(e[32:29]), 64'(g[32:29]));
      chk("agc_track", 64'(e[28:26]), 64'(g[28:26]));
      chk("dc_loop", 64'(e[25:22]), 64'(g[25:22]));
      chk("samples", 64'(e[21:10]), 64'(g[21:10]));
      chk("tbus_addr", 64'(e[9:2]), 64'(g[9:2]));
      chk("energy_det", 64'(e[1]), 64'(g[1]));
      chk("filter_weights", 64'(e[0]), 64'(g[0]));
      for (int k = 0; k < 8; k++) rd(OFS[k], r[k]);
      rd(BAD[i % 4], 8'h00);
      // write then read at once: the new value must already be stored
      wr(OFS[6], v2[23:16]);
      rd(OFS[6], v2[23:16]);
    end
    $display("test random_config done");
    close_out();
  end
endmodule // tb
